// File: src/rss_pkg.sv
package rss_pkg;
	localparam int W = 12;
	typedef logic [W-1:0] rss_cnt_t;
	localparam rss_cnt_t CNT_ONE = 12'h001;
	localparam rss_cnt_t CNT_ZERO = 12'h000;

	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STEP = 8'h04;
	localparam logic [7:0] A_DIV = 8'h08;
	localparam logic [7:0] A_LIMIT = 8'h0C;
	localparam logic [7:0] A_FCNT = 8'h10;
	localparam logic [7:0] A_STAT = 8'h14;
	localparam logic [7:0] A_MASK = 8'h18;
	localparam logic [7:0] A_CNT = 8'h1C;

	// CTRL bits
	localparam int C_EN = 0;
	localparam int C_AUTO = 1;
	localparam int C_FCLR = 2;

	// Reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam rss_cnt_t STEP_RST = 12'h004;
	localparam logic [3:0] DIV_RST = 4'h1;
	localparam rss_cnt_t LIMIT_RST = 12'h800;
	localparam logic [3:0] FCNT_RST = 4'h3;
	localparam logic [3:0] NIB_ONE = 4'h1;
	localparam logic [3:0] NIB_ZERO = 4'h0;

	// Event / status bits
	localparam int EV_W = 4;
	localparam int E_SSGO = 0;
	localparam int E_SSEND = 1;
	localparam int E_TMAX = 2;
	localparam int E_FLT = 3;

	// Counter view register fields
	localparam int F_RAMP = 0;
	localparam int F_SS = 12;
	localparam int F_FLT = 13;
	localparam int F_REP = 14;
	localparam int F_CNT = 16;

	// Auto-recovery wait
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned RECOV_NS = 1000000;
	localparam int RC_W = 14;

	typedef struct packed {
		logic hs_on;
		logic ls_on;
	} rss_drv_t;

	typedef struct packed {
		logic seq_done;
		logic oncmp_hi;
		logic fb_skip;
		logic fb_reg;
		logic dt_done;
	} rss_sense_t;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_HS = 6'h02,
		S_DT1 = 6'h04,
		S_LS = 6'h08,
		S_DT2 = 6'h10,
		S_FLT = 6'h20
	} rss_state_t;
endpackage

// File: src/rss_sync.sv
`timescale 1ns/10ps
`default_nettype none
module rss_sync #(
	parameter int WD = 1
) (
	input wire logic mclk, // Clock
	input wire logic resetn, // Async reset, active low
	input wire logic [WD-1:0] din, // Asynchronous input
	output logic [WD-1:0] dout // Filtered, synchronous
);
	logic [WD-1:0] s1_q, s2_q, s3_q, out_q, out_d;

	always_comb begin
		out_d = (s2_q == s3_q) ? s3_q : out_q;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			out_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign dout = out_q;
endmodule
`default_nettype wire

// File: src/rss_dac.sv
`timescale 1ns/10ps
`default_nettype none
module rss_dac (
	input wire logic mclk, // Clock
	input wire logic resetn, // Async reset, active low
	input wire logic active, // Soft-start placed
	input wire rss_pkg::rss_cnt_t ramp, // Ramp counter bus
	output rss_pkg::rss_cnt_t dac_ref // Comparator reference code
);
	rss_pkg::rss_cnt_t ref_q, ref_d;

	// Held at zero until soft-start, then tracks every ramp step
	always_comb begin
		ref_d = active ? ramp : rss_pkg::CNT_ZERO; // [RULE_12]
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ref_q <= rss_pkg::CNT_ZERO;
		end else begin
			ref_q <= ref_d;
		end
	end

	assign dac_ref = ref_q;
endmodule
`default_nettype wire

// File: src/rss_core.sv
// How it works
// RULE_01 - Startup completion loads the ramp counter with last high-side on-time.
// RULE_02 - Ramp counter only counts up and saturates at longest on-interval.
// RULE_03 - Each low-side pulse advances the ramp by the programmed step size.
// RULE_04 - Low-side pulses may be divided so only every Nth advances.
// RULE_05 - Skip-entry or in-regulation feedback forces the ramp to its maximum.
// RULE_06 - On-time counter counts up in high side, down to zero in low side.
// RULE_07 - Count direction flips on reaching the limit or comparator end.
// RULE_08 - Configured number of limit events gives latch-off or auto-recovery.
// RULE_09 - During soft-start the limit reference reloads from ramp each cycle.
// RULE_10 - Limit faults ignored in soft-start; enabled when ramp equals limit.
// RULE_11 - Current-sense comparator ending first takes precedence over limit.
// RULE_12 - D/A reference is held low then follows each ramp increment.
// RULE_13 - After load, high side stays on while counter climbs to ramp value.
// RULE_14 - Dead-time then low side on until on-time counter returns to zero.
// RULE_15 - Repetition feature off at soft-start, on once comparator drops in-cycle.
// RULE_16 - Start only when zero-voltage interval is under twice last on-time.
// RULE_17 - Ramp, on-time counter and limit share one width and time base.
`timescale 1ns/10ps
`default_nettype none
module rss_core #(
	parameter int RECOV_CYC = rss_pkg::RECOV_NS / rss_pkg::CLK_NS
) (
	input wire logic mclk, // Clock, 10 MHz
	input wire logic resetn, // Async reset, active low
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	input wire rss_pkg::rss_sense_t sense, // Async status pins
	input wire rss_pkg::rss_cnt_t last_on_time, // Last startup high-side on-time
	input wire rss_pkg::rss_cnt_t zvs_interval, // Turn-off to ZVS interval
	output rss_pkg::rss_drv_t drv, // Gate requests
	output rss_pkg::rss_cnt_t dac_ref, // On-time comparator reference
	output logic rep_en, // Previous on-time repetition enable
	output logic fault, // Protection active
	output logic irq // Interrupt, level
);
	rss_pkg::rss_sense_t sn;
	rss_pkg::rss_cnt_t last_s, zvs_s;
	logic dt_prev_q, seq_prev_q;
	logic dt_rise, seq_rise, start_ev;

	rss_sync #(.WD($bits(rss_pkg::rss_sense_t))) u_sync_sense (
		.mclk(mclk),
		.resetn(resetn),
		.din(sense),
		.dout(sn)
	);
	rss_sync #(.WD(rss_pkg::W)) u_sync_last (
		.mclk(mclk),
		.resetn(resetn),
		.din(last_on_time),
		.dout(last_s)
	);
	rss_sync #(.WD(rss_pkg::W)) u_sync_zvs (
		.mclk(mclk),
		.resetn(resetn),
		.din(zvs_interval),
		.dout(zvs_s)
	);

	// Register file
	logic [1:0] ctrl_q, ctrl_d;
	rss_pkg::rss_cnt_t step_q, step_d, limit_q, limit_d;
	logic [3:0] div_q, div_d, fset_q, fset_d;
	logic [rss_pkg::EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic [31:0] hrdata_q, hrdata_d;
	logic dph_q, dph_d, irq_q, irq_d;
	logic [7:0] waddr_q, waddr_d;
	logic aph, fclr;

	// Control state
	rss_pkg::rss_state_t state_q, state_d;
	rss_pkg::rss_cnt_t ramp_q, ramp_d, cnt_q, cnt_d, lref_q, lref_d;
	rss_pkg::rss_drv_t drv_q, drv_d;
	logic [3:0] lsdiv_q, lsdiv_d, fcnt_q, fcnt_d;
	logic [rss_pkg::RC_W-1:0] rc_q, rc_d;
	logic ss_q, ss_d, rep_q, rep_d, flt_q, flt_d;
	logic [rss_pkg::W:0] ramp_sum;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	assign dt_rise = sn.dt_done & ~dt_prev_q;
	assign seq_rise = sn.seq_done & ~seq_prev_q;
	assign start_ev = seq_rise && ctrl_q[rss_pkg::C_EN] && state_q == rss_pkg::S_IDLE
		&& ({1'b0, zvs_s} < {last_s, 1'b0}); // [RULE_16]
	assign aph = hsel && htrans[1] && hready;
	assign fclr = dph_q && hit(waddr_q, rss_pkg::A_CTRL) && hwdata[rss_pkg::C_FCLR];

	// Bus slave: zero wait, read data fetched in address phase
	always_comb begin
		dph_d = aph && hwrite;
		waddr_d = aph ? haddr[7:0] : waddr_q;
		hrdata_d = 32'h0000_0000;
		if (aph && !hwrite) begin
			if (hit(haddr[7:0], rss_pkg::A_CTRL)) hrdata_d[1:0] = ctrl_q;
			if (hit(haddr[7:0], rss_pkg::A_STEP)) hrdata_d[rss_pkg::W-1:0] = step_q;
			if (hit(haddr[7:0], rss_pkg::A_DIV)) hrdata_d[3:0] = div_q;
			if (hit(haddr[7:0], rss_pkg::A_LIMIT)) hrdata_d[rss_pkg::W-1:0] = limit_q;
			if (hit(haddr[7:0], rss_pkg::A_FCNT)) hrdata_d[3:0] = fset_q;
			if (hit(haddr[7:0], rss_pkg::A_STAT)) hrdata_d[rss_pkg::EV_W-1:0] = stat_q;
			if (hit(haddr[7:0], rss_pkg::A_MASK)) hrdata_d[rss_pkg::EV_W-1:0] = mask_q;
			if (hit(haddr[7:0], rss_pkg::A_CNT)) begin
				hrdata_d[rss_pkg::F_RAMP +: rss_pkg::W] = ramp_q;
				hrdata_d[rss_pkg::F_SS] = ss_q;
				hrdata_d[rss_pkg::F_FLT] = flt_q;
				hrdata_d[rss_pkg::F_REP] = rep_q;
				hrdata_d[rss_pkg::F_CNT +: rss_pkg::W] = cnt_q;
			end
		end
		ctrl_d = ctrl_q;
		step_d = step_q;
		div_d = div_q;
		limit_d = limit_q;
		fset_d = fset_q;
		mask_d = mask_q;
		stat_d = stat_q | ev;
		if (dph_q) begin
			if (hit(waddr_q, rss_pkg::A_CTRL)) ctrl_d = hwdata[1:0];
			if (hit(waddr_q, rss_pkg::A_STEP)) step_d = hwdata[rss_pkg::W-1:0];
			if (hit(waddr_q, rss_pkg::A_DIV)) div_d = hwdata[3:0];
			if (hit(waddr_q, rss_pkg::A_LIMIT)) limit_d = hwdata[rss_pkg::W-1:0];
			if (hit(waddr_q, rss_pkg::A_FCNT)) fset_d = hwdata[3:0];
			if (hit(waddr_q, rss_pkg::A_MASK)) mask_d = hwdata[rss_pkg::EV_W-1:0];
			// Set wins over the write-one clear
			if (hit(waddr_q, rss_pkg::A_STAT)) begin
				stat_d = (stat_q & ~hwdata[rss_pkg::EV_W-1:0]) | ev;
			end
		end
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dph_q <= 1'b0;
			waddr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			ctrl_q <= rss_pkg::CTRL_RST;
			step_q <= rss_pkg::STEP_RST;
			div_q <= rss_pkg::DIV_RST;
			limit_q <= rss_pkg::LIMIT_RST;
			fset_q <= rss_pkg::FCNT_RST;
			stat_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			dph_q <= dph_d;
			waddr_q <= waddr_d;
			hrdata_q <= hrdata_d;
			ctrl_q <= ctrl_d;
			step_q <= step_d;
			div_q <= div_d;
			limit_q <= limit_d;
			fset_q <= fset_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
		end
	end

	// Switching sequencer
	always_comb begin
		state_d = state_q;
		ramp_d = ramp_q;
		cnt_d = cnt_q;
		lref_d = lref_q;
		lsdiv_d = lsdiv_q;
		fcnt_d = fcnt_q;
		rc_d = rc_q;
		ss_d = ss_q;
		rep_d = rep_q;
		flt_d = flt_q;
		ev = '0;
		ramp_sum = {1'b0, ramp_q} + {1'b0, step_q};
		unique case (state_q)
			rss_pkg::S_IDLE: begin
				if (start_ev) begin
					ramp_d = last_s; // [RULE_01]
					lref_d = last_s; // [RULE_13]
					cnt_d = rss_pkg::CNT_ZERO;
					lsdiv_d = rss_pkg::NIB_ZERO;
					fcnt_d = rss_pkg::NIB_ZERO;
					ss_d = 1'b1;
					rep_d = 1'b0; // [RULE_15]
					ev[rss_pkg::E_SSGO] = 1'b1;
					state_d = rss_pkg::S_HS;
				end
			end
			rss_pkg::S_HS: begin
				if (!sn.oncmp_hi) begin
					rep_d = 1'b1; // [RULE_15]
					state_d = rss_pkg::S_DT1; // [RULE_11] [RULE_07]
				end else if (cnt_q >= lref_q) begin
					state_d = rss_pkg::S_DT1; // [RULE_07]
					if (!ss_q) begin
						ev[rss_pkg::E_TMAX] = 1'b1; // [RULE_10]
						fcnt_d = fcnt_q + rss_pkg::NIB_ONE;
						if (fcnt_d >= fset_q) begin
							flt_d = 1'b1; // [RULE_08]
							ev[rss_pkg::E_FLT] = 1'b1;
							rc_d = '0;
							state_d = rss_pkg::S_FLT;
						end
					end
				end else begin
					cnt_d = cnt_q + rss_pkg::CNT_ONE; // [RULE_06] [RULE_13]
				end
			end
			rss_pkg::S_DT1: begin
				if (dt_rise) begin
					state_d = rss_pkg::S_LS; // [RULE_14]
					// Each low-side pulse clocks the ramp, optionally divided
					if (lsdiv_q + rss_pkg::NIB_ONE >= div_q) begin // [RULE_04]
						lsdiv_d = rss_pkg::NIB_ZERO;
						if (ss_q && ramp_q < limit_q) begin
							ramp_d = (ramp_sum >= {1'b0, limit_q}) ? limit_q
								: ramp_sum[rss_pkg::W-1:0]; // [RULE_02] [RULE_03]
						end
					end else begin
						lsdiv_d = lsdiv_q + rss_pkg::NIB_ONE;
					end
				end
			end
			rss_pkg::S_LS: begin
				if (cnt_q == rss_pkg::CNT_ZERO) begin
					state_d = rss_pkg::S_DT2; // [RULE_14]
				end else begin
					cnt_d = cnt_q - rss_pkg::CNT_ONE; // [RULE_06]
				end
			end
			rss_pkg::S_DT2: begin
				if (dt_rise) begin
					lref_d = ss_q ? ramp_q : limit_q; // [RULE_09] [RULE_17]
					state_d = rss_pkg::S_HS;
				end
			end
			rss_pkg::S_FLT: begin
				if (ctrl_q[rss_pkg::C_AUTO]) begin
					rc_d = rc_q + 1'b1;
					if (rc_q >= rss_pkg::RC_W'(RECOV_CYC - 1)) begin
						flt_d = 1'b0; // [RULE_08]
						state_d = rss_pkg::S_IDLE;
					end
				end else if (fclr) begin
					flt_d = 1'b0; // [RULE_08]
					state_d = rss_pkg::S_IDLE;
				end
			end
			default: state_d = rss_pkg::S_IDLE;
		endcase
		// Feedback ends soft-start early
		if (ss_q && (sn.fb_skip || sn.fb_reg) && ramp_q < limit_q) begin
			ramp_d = limit_q; // [RULE_05]
		end
		if (ss_q && ramp_q >= limit_q) begin
			ss_d = 1'b0; // [RULE_10]
			ev[rss_pkg::E_SSEND] = 1'b1;
		end
		if (!ctrl_q[rss_pkg::C_EN] && state_q != rss_pkg::S_FLT) begin
			state_d = rss_pkg::S_IDLE;
			ss_d = 1'b0;
		end
		drv_d.hs_on = (state_d == rss_pkg::S_HS); // [RULE_13]
		drv_d.ls_on = (state_d == rss_pkg::S_LS); // [RULE_14]
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= rss_pkg::S_IDLE;
			ramp_q <= rss_pkg::CNT_ZERO;
			cnt_q <= rss_pkg::CNT_ZERO;
			lref_q <= rss_pkg::CNT_ZERO;
			lsdiv_q <= rss_pkg::NIB_ZERO;
			fcnt_q <= rss_pkg::NIB_ZERO;
			rc_q <= '0;
			ss_q <= 1'b0;
			rep_q <= 1'b0;
			flt_q <= 1'b0;
			drv_q <= '0;
			dt_prev_q <= 1'b0;
			seq_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ramp_q <= ramp_d;
			cnt_q <= cnt_d;
			lref_q <= lref_d;
			lsdiv_q <= lsdiv_d;
			fcnt_q <= fcnt_d;
			rc_q <= rc_d;
			ss_q <= ss_d;
			rep_q <= rep_d;
			flt_q <= flt_d;
			drv_q <= drv_d;
			dt_prev_q <= sn.dt_done;
			seq_prev_q <= sn.seq_done;
		end
	end

	rss_dac u_dac (
		.mclk(mclk),
		.resetn(resetn),
		.active(ss_q || state_q != rss_pkg::S_IDLE),
		.ramp(ramp_q),
		.dac_ref(dac_ref)
	);

	logic hresp_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1 | hresp_q;
	assign hresp = hresp_q;
	assign drv = drv_q;
	assign rep_en = rep_q;
	assign fault = flt_q;
	assign irq = irq_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	drv_excl_a: assert property (!(drv_q.hs_on && drv_q.ls_on)) // [RULE_14]
		else $error("both switches on");
	ramp_load_a: assert property (start_ev |=> ramp_q == $past(last_s)) // [RULE_01]
		else $error("ramp not loaded");
	ramp_mono_a: assert property (ss_q && $past(ss_q) |-> ramp_q >= $past(ramp_q)) // [RULE_02]
		else $error("ramp decreased");
	cnt_up_a: assert property (state_q == rss_pkg::S_HS && $past(state_q) == rss_pkg::S_HS
		|-> cnt_q == $past(cnt_q) + rss_pkg::CNT_ONE) // [RULE_06]
		else $error("count up wrong");
	lim_flip_a: assert property (state_q == rss_pkg::S_HS && sn.oncmp_hi && cnt_q >= lref_q
		&& ctrl_q[rss_pkg::C_EN] |=> state_q inside {rss_pkg::S_DT1, rss_pkg::S_FLT}) // [RULE_07]
		else $error("no flip at limit");
	cmp_prec_a: assert property (state_q == rss_pkg::S_HS && !sn.oncmp_hi && ctrl_q[rss_pkg::C_EN]
		|=> state_q == rss_pkg::S_DT1 && fcnt_q == $past(fcnt_q)) // [RULE_11]
		else $error("comparator lost precedence");
	ls_end_a: assert property (state_q == rss_pkg::S_LS && cnt_q == rss_pkg::CNT_ZERO
		&& ctrl_q[rss_pkg::C_EN] |=> state_q == rss_pkg::S_DT2 ##0 !drv_q.ls_on) // [RULE_14]
		else $error("low side overrun");
	ss_ignore_a: assert property (ss_q && $past(ss_q) |-> fcnt_q == $past(fcnt_q)) // [RULE_10]
		else $error("fault counted in soft-start");
	fb_end_a: assert property (ss_q && (sn.fb_skip || sn.fb_reg) && ramp_q < limit_q
		|=> ramp_q == $past(limit_q) ##1 !ss_q) // [RULE_05]
		else $error("feedback did not end soft-start");
	ref_load_a: assert property (ss_q && state_q == rss_pkg::S_DT2 && dt_rise
		&& ctrl_q[rss_pkg::C_EN] |=> lref_q == $past(ramp_q)) // [RULE_09]
		else $error("reference not reloaded");
	rep_off_a: assert property (start_ev |=> !rep_en) // [RULE_15]
		else $error("repetition not disabled");

	ss_end_c: cover property (ss_q ##1 !ss_q);
	fault_c: cover property (!flt_q ##1 flt_q);
	cmp_end_c: cover property (state_q == rss_pkg::S_HS && !sn.oncmp_hi);
	irq_c: cover property (irq_q);
endmodule
`default_nettype wire

// File: bench/rss_bridge.sv
`timescale 1ns/10ps
`default_nettype none
module rss_bridge (
	input wire logic mclk, // Clock
	input wire logic resetn, // Async reset, active low
	input wire rss_pkg::rss_drv_t drv, // Gate requests from the core
	input wire logic [7:0] dt_cyc, // Bridge transition time in cycles
	input wire logic [7:0] cut, // Comparator trip after this many cycles, 0 never
	output logic oncmp_hi, // Current comparator, high keeps high side on
	output logic dt_done // Bridge transition finished
);
	logic [7:0] dc;
	logic [7:0] hc;
	// Comparator trips only when a cut is commanded; bridge settles after dt_cyc
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dc <= 8'h00;
			hc <= 8'h00;
			oncmp_hi <= 1'b1;
			dt_done <= 1'b0;
		end else begin
			hc <= drv.hs_on ? hc + 8'h01 : 8'h00;
			oncmp_hi <= !(drv.hs_on && cut != 8'h00 && hc >= cut);
			if (drv.hs_on || drv.ls_on) begin
				dc <= 8'h00;
				dt_done <= 1'b0;
			end else if (dc < dt_cyc) begin
				dc <= dc + 8'h01;
			end else begin
				dt_done <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int RC = 20;
	logic mclk, resetn, hsel, hwrite, hready, hresp, hreadyout, rep_en, fault, irq;
	logic sq, oc, fs, fr, dt;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0] dtc, cut;
	rss_pkg::rss_cnt_t lot, zvs, dac_ref, lim;
	rss_pkg::rss_drv_t drv;
	rss_pkg::rss_sense_t sense;
	int n_errors, checks, hc, lc, i, j, k, s, d, n;
	int hs_w[$];
	int ls_w[$];
	logic [7:0] ra[8];
	logic [31:0] rv[8];
	assign hready = hreadyout;
	assign sense = '{seq_done: sq, oncmp_hi: oc, fb_skip: fs, fb_reg: fr, dt_done: dt};
	rss_core #(.RECOV_CYC(RC)) dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sense(sense),
		.last_on_time(lot), .zvs_interval(zvs), .drv(drv), .dac_ref(dac_ref),
		.rep_en(rep_en), .fault(fault), .irq(irq));
	rss_bridge far (.mclk(mclk), .resetn(resetn), .drv(drv), .dt_cyc(dtc), .cut(cut),
		.oncmp_hi(oc), .dt_done(dt));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Gate pulse widths in cycles
	always @(posedge mclk) begin
		if (drv.hs_on)
			hc++;
		else if (hc > 0) begin
			hs_w.push_back(hc);
			hc = 0;
		end
		if (drv.ls_on)
			lc++;
		else if (lc > 0) begin
			ls_w.push_back(lc);
			lc = 0;
		end
	end
	function automatic logic ok_step(int a, int b, int st, int cap);
		return b == a || b == a + st || (b == cap && b > a && b < a + st);
	endfunction
	function automatic logic near(int a, int b);
		return a - b <= 1 && b - a <= 1;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge mclk);
		while (hready !== 1'b1) @(posedge mclk);
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		ahb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask
	task automatic start(input rss_pkg::rss_cnt_t l, input rss_pkg::rss_cnt_t z);
		@(posedge mclk);
		lot <= l;
		zvs <= z;
		repeat (6) @(posedge mclk);
		sq <= 1'b1;
		repeat (8) @(posedge mclk);
		sq <= 1'b0;
	endtask
	task automatic idle;
		ahb(1'b1, rss_pkg::A_CTRL, 32'h4);
		ahb(1'b1, rss_pkg::A_STAT, 32'hF);
		hs_w.delete();
		ls_w.delete();
	endtask
	task automatic give_verdict;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge mclk);
		n_errors++;
		give_verdict();
	end
	initial begin
		resetn = 1'b0;
		{hsel, htrans, haddr, hwrite, hwdata, sq, fs, fr, lot, zvs, cut} = '0;
		{n_errors, checks, hc, lc} = '0;
		void'($urandom(64172));
		s = $urandom_range(4, 1);
		d = $urandom_range(3, 0);
		dtc = 8'($urandom_range(5, 2));
		lim = 12'h030;
		ra = '{rss_pkg::A_CTRL, rss_pkg::A_STEP, rss_pkg::A_DIV, rss_pkg::A_LIMIT,
			rss_pkg::A_FCNT, rss_pkg::A_STAT, rss_pkg::A_MASK, 8'h20};
		rv = '{32'(rss_pkg::CTRL_RST), 32'(rss_pkg::STEP_RST), 32'(rss_pkg::DIV_RST),
			32'(rss_pkg::LIMIT_RST), 32'(rss_pkg::FCNT_RST), 32'h0, 32'h0, 32'h0};
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		for (i = 0; i < 8; i++) rchk(ra[i], 32'hFFFFFFFF, rv[i], "reg_reset");
		chk("dac_idle", 32'h0, 32'(dac_ref));
		chk("hresp", 0, hresp);
		ahb(1'b1, rss_pkg::A_STEP, 32'(s));
		ahb(1'b1, rss_pkg::A_DIV, 32'(d));
		ahb(1'b1, rss_pkg::A_LIMIT, 32'(lim));
		ahb(1'b1, rss_pkg::A_FCNT, 32'h3);
		ahb(1'b1, rss_pkg::A_MASK, 32'hF);
		ahb(1'b1, rss_pkg::A_CTRL, 32'h1);
		rchk(rss_pkg::A_STEP, 32'hFFF, 32'(s), "step");
		start(12'h010, 12'h008);
		for (i = 0; i < 60000 && fault !== 1'b1; i++) @(posedge mclk);
		repeat (2) @(posedge mclk);
		chk("first_hs", 32'h11, 32'(hs_w[0]));
		j = 0;
		for (i = 1; i < hs_w.size(); i++) begin
			chk("ls_len", 1, near(hs_w[i-1], ls_w[i-1]));
			chk("hs_step", 1, ok_step(hs_w[i-1], hs_w[i], s, lim + 1));
			if (hs_w[i] != hs_w[i-1]) begin
				if (j > 0)
					chk("div_run", (d < 2) ? 1 : d, i - j);
				j = i;
			end
		end
		chk("cap_hs", 32'(lim) + 1, 32'(hs_w[$]));
		chk("cap_run", 1, hs_w.size() - j >= 3);
		chk("fault_drv", 32'h0, 32'(drv));
		chk("dac_cap", 32'(lim), 32'(dac_ref));
		chk("irq", 1, irq);
		chk("rep_off", 0, rep_en);
		rchk(rss_pkg::A_STAT, 32'hF, 32'hF, "stat");
		rchk(rss_pkg::A_CNT, 32'h7FFF, 32'h2000 | 32'(lim), "cnt");
		idle();
		chk("fault_clr", 0, fault);
		for (k = 0; k < 2; k++) begin
			cut <= k ? 8'h00 : 8'($urandom_range(10, 6));
			ahb(1'b1, rss_pkg::A_CTRL, k ? 32'h3 : 32'h1);
			start(12'h020, 12'h010);
			for (i = 0; i < 3000 && hs_w.size() < 2; i++) @(posedge mclk);
			chk("hs_count", 1, hs_w.size() >= 2);
			if (k == 0) begin
				chk("cut_hs", 1, hs_w[1] < 33);
				chk("cut_ls", 1, near(hs_w[0], ls_w[0]));
				chk("rep_on", 1, rep_en);
			end
			fs <= !k;
			fr <= k;
			repeat (12) @(posedge mclk);
			rchk(rss_pkg::A_CNT, 32'hFFF, 32'(lim), "ramp_forced");
			if (k == 1) begin
				for (i = 0; i < 3000 && fault !== 1'b1; i++) @(posedge mclk);
				for (n = 0; n < 200 && fault === 1'b1; n++) @(posedge mclk);
				chk("recov", 1, n >= RC - 1 && n <= RC + 2);
				repeat (3) @(posedge mclk);
				chk("recov_idle", 32'h0, 32'(drv));
			end
			fs <= 1'b0;
			fr <= 1'b0;
			idle();
		end
		ahb(1'b1, rss_pkg::A_MASK, 32'h0);
		ahb(1'b1, rss_pkg::A_CTRL, 32'h1);
		start(12'h010, 12'h020);
		repeat (20) @(posedge mclk);
		chk("refused", 0, hs_w.size());
		rchk(rss_pkg::A_STAT, 32'hF, 32'h0, "stat_refused");
		start(12'h010, 12'h01F);
		chk("irq_masked", 0, irq);
		rchk(rss_pkg::A_STAT, 32'h1, 32'h1, "stat_go");
		ahb(1'b1, rss_pkg::A_MASK, 32'h1);
		repeat (2) @(posedge mclk);
		chk("irq_on", 1, irq);
		ahb(1'b1, rss_pkg::A_STAT, 32'h1);
		repeat (2) @(posedge mclk);
		chk("irq_clr", 0, irq);
		give_verdict();
	end
endmodule
`default_nettype wire
